/* hw/vfd_cmd_pkg.sv */
// Constants and types shared by the serial command decoder of the
// dot-matrix fluorescent display controller.
// Assumes a SystemVerilog-2012 tool flow; holds definitions only.
`default_nettype none

package vfd_cmd_pkg;

  // Clock period of the core domain in nanoseconds, for reference by the bench.
  localparam int MCLK_PERIOD_NS = 8;

  // Command codes, upper nibble of the first byte of a transfer; the null command is a whole byte.
  localparam logic [3:0] OP_ADDR    = 4'h8;
  localparam logic [3:0] OP_CHAR    = 4'h9;
  localparam logic [3:0] OP_DIM     = 4'hA;
  localparam logic [3:0] OP_DIGITS  = 4'hB;
  localparam logic [3:0] OP_MODE    = 4'hC;
  localparam logic [3:0] OP_CURSOR  = 4'hD;
  localparam logic [3:0] OP_KEYREAD = 4'hE;
  localparam logic [7:0] CMD_NULL   = 8'h00;

  // Mode select codes carried in the low three bits of the mode command.
  localparam logic [2:0] MODE_LAMP   = 3'h1;
  localparam logic [2:0] MODE_LOWPWR = 3'h2;
  localparam logic [2:0] MODE_BLANK  = 3'h4;

  // Dimming: slot length and the largest usable on-time, in oscillator periods.
  localparam logic [10:0] DIM_SLOT  = 11'h400;
  localparam logic [9:0]  DIM_MAX   = 10'h3D0;
  localparam logic [9:0]  DIM_RESET = 10'h000;

  // Digit pair count: code zero stands for sixteen pairs.
  localparam logic [3:0] PAIRS_RESET = 4'h0;
  localparam logic [4:0] PAIRS_FULL  = 5'h10;

  // Display memory.
  localparam int         MEM_DEPTH  = 32;
  localparam logic [4:0] ADDR_LAST  = 5'h1F;
  localparam logic [4:0] ADDR_RESET = 5'h00;

  // Status byte values returned during ordinary commands.
  localparam logic [7:0] STAT_NEW  = 8'h00;
  localparam logic [7:0] STAT_NONE = 8'hFF;

  // Key data framing: status byte then one byte per row.
  localparam int         KEY_ROWS   = 5;
  localparam int         KEY_COLS   = 6;
  localparam logic [2:0] FRAME_LAST = 3'h5;
  localparam logic [2:0] BIT_LAST   = 3'h7;
  localparam logic [2:0] IDX_SAT    = 3'h7;

  // Cursor byte lanes in arrival order.
  localparam logic [2:0] CUR_L1_LO = 3'h0;
  localparam logic [2:0] CUR_L1_HI = 3'h1;
  localparam logic [2:0] CUR_L2_LO = 3'h2;
  localparam logic [2:0] CUR_L2_HI = 3'h3;

  typedef enum logic [1:0] {
    OPM_NORMAL = 2'b00,
    OPM_LAMP   = 2'b01,
    OPM_BLANK  = 2'b11,
    OPM_LOWPWR = 2'b10
  } op_mode_e;

  typedef enum logic [1:0] {
    ST_CMD    = 2'b00,
    ST_DATA   = 2'b01,
    ST_IGNORE = 2'b11
  } dec_state_e;

  // Everything the link side shifts out during one transfer.
  typedef struct packed {
    logic [7:0]                          status;
    logic [KEY_ROWS-1:0][KEY_COLS-1:0]   rows;
  } key_frame_s;

  // Cursor bitmaps, one bit per digit of each line.
  typedef struct packed {
    logic [15:0] line2_cursor_bits;
    logic [15:0] line1_cursor_bits;
  } cursor_s;

endpackage

`default_nettype wire

/* hw/vfd_spi_command_decoder.sv */
// Serial command decoder of a two-line dot-matrix fluorescent display
// controller: byte framing on the serial link, command decode, display
// memory, dimming, digit count, mode, cursor and key data read-back.
// Assumes a scan engine on mclk that supplies key states and a one-cycle
// change event, and a display engine that reads memory by line and digit.
`default_nettype none

module vfd_spi_command_decoder (
  input  wire logic                  mclk,              // Core clock, 125 MHz.
  input  wire logic                  resetn,            // Asynchronous reset, active low.
  input  wire logic                  spi_sclk,          // Link clock, idles high.
  input  wire logic                  spi_cs_n,          // Chip select, active low.
  input  wire logic                  spi_mosi,          // Serial data in, MSB first.
  output var  logic                  spi_miso_o,        // Serial data out.
  output var  logic                  spi_miso_oe_n,     // Low while data out is driven.
  input  wire logic [29:0]           key_state,         // Row-major key states, 1 = pressed.
  input  wire logic                  key_new_event,     // One-cycle pulse: new key data.
  output var  logic                  key_change_irq_n,  // Key interrupt, active low.
  output var  logic                  key_scan_stop,     // One-cycle pulse: stop scanning.
  output var  logic                  key_scan_hold,     // Pause scan while a transfer runs.
  input  wire logic                  disp_line,         // Line to read: 0 = line 1.
  input  wire logic [3:0]            disp_digit,        // Digit within the line.
  output var  logic [7:0]            disp_char,         // Character code read back.
  output var  logic                  disp_digit_on,     // Digit lies inside the count.
  output var  logic                  seg_force_on,      // Lamp test: all segments on.
  output var  logic                  seg_force_off,     // Blank: all segments off.
  output var  logic                  low_power,         // Low power mode selected.
  output var  logic [9:0]            dimming_on_time,   // Per-digit on-time.
  output var  logic [4:0]            digit_pair_count,  // Pairs shown, 1 to 16.
  output var  vfd_cmd_pkg::cursor_s  cursor_output      // Inverted cursor drive.
);
  import vfd_cmd_pkg::*;

  // Link side. Chip select high is the link reset, so every transfer starts
  // from bit zero even if the host aborted the previous one mid-byte.
  logic [6:0] rx_shift;
  logic [2:0] rx_bit;
  logic       rx_first_done;
  logic       cmd_is_key;
  logic [6:0] next_rx_shift;
  logic [2:0] next_rx_bit;
  logic       next_rx_first_done;
  logic       next_cmd_is_key;
  logic [7:0] rx_data;
  logic       rx_toggle;
  logic [7:0] next_rx_data;
  logic       next_rx_toggle;
  logic [7:0] rx_full;
  logic       rx_done;

  // Sample on the rising link clock edge and spot the eighth bit.
  always_comb begin
    rx_full            = {rx_shift, spi_mosi};
    rx_done            = (rx_bit == BIT_LAST);
    next_rx_shift      = rx_full[6:0];
    next_rx_bit        = rx_bit + 3'h1;
    next_rx_first_done = rx_first_done;
    next_cmd_is_key    = cmd_is_key;
    next_rx_data       = rx_data;
    next_rx_toggle     = rx_toggle;
    if (rx_done) begin
      next_rx_data   = rx_full;
      next_rx_toggle = ~rx_toggle;
      if (!rx_first_done) begin
        next_rx_first_done = 1'b1;
        next_cmd_is_key    = (rx_full[7:4] == OP_KEYREAD) || (rx_full == CMD_NULL);
      end
    end
  end

  always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      rx_shift      <= 7'h00;
      rx_bit        <= 3'h0;
      rx_first_done <= 1'b0;
      cmd_is_key    <= 1'b0;
    end else begin
      rx_shift      <= next_rx_shift;
      rx_bit        <= next_rx_bit;
      rx_first_done <= next_rx_first_done;
      cmd_is_key    <= next_cmd_is_key;
    end
  end

  // The byte and its toggle survive chip select, or the core would see a
  // spurious edge each time a transfer ends on an odd byte count.
  always_ff @(posedge spi_sclk or negedge resetn) begin
    if (!resetn) begin
      rx_data   <= 8'h00;
      rx_toggle <= 1'b0;
    end else begin
      rx_data   <= next_rx_data;
      rx_toggle <= next_rx_toggle;
    end
  end

  // Transmit position advances on the falling edge. The first falling edge
  // only marks the start, since the first bit is already on the line.
  logic       tx_started;
  logic [2:0] tx_bit;
  logic [2:0] tx_byte;
  logic       next_tx_started;
  logic [2:0] next_tx_bit;
  logic [2:0] next_tx_byte;
  key_frame_s frame;
  logic [7:0] tx_sel;

  always_comb begin
    next_tx_started = 1'b1;
    next_tx_bit     = tx_bit;
    next_tx_byte    = tx_byte;
    if (tx_started) begin
      next_tx_bit = tx_bit + 3'h1;
      if (tx_bit == BIT_LAST) begin
        next_tx_byte = (tx_byte == FRAME_LAST) ? 3'h0 : tx_byte + 3'h1;
      end
    end
  end

  always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      tx_started <= 1'b0;
      tx_bit     <= 3'h0;
      tx_byte    <= 3'h0;
    end else begin
      tx_started <= next_tx_started;
      tx_bit     <= next_tx_bit;
      tx_byte    <= next_tx_byte;
    end
  end

  // Byte zero is always status; key commands follow it with the rows.
  always_comb begin
    tx_sel = frame.status;
    if (cmd_is_key && (tx_byte != 3'h0)) begin
      tx_sel = {2'b00, frame.rows[tx_byte - 3'h1]};
    end
  end

  // Chip select gates the driver directly so the line is released at once.
  assign spi_miso_o    = tx_sel[BIT_LAST - tx_bit];
  assign spi_miso_oe_n = spi_cs_n;

  // Core side: reset release, chip select level and byte toggle crossings.
  logic rst_meta;
  logic rst_n;
  logic cs_meta;
  logic cs_sync;
  logic cs_prev;
  logic tg_meta;
  logic tg_sync;
  logic tg_prev;
  logic byte_strobe;
  logic cs_rise;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
      tg_meta <= 1'b0;
      tg_sync <= 1'b0;
      tg_prev <= 1'b0;
    end else begin
      cs_meta <= spi_cs_n;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
      tg_meta <= rx_toggle;
      tg_sync <= tg_meta;
      tg_prev <= tg_sync;
    end
  end

  // The held byte is stable for a whole byte time once its toggle lands.
  assign byte_strobe = tg_sync ^ tg_prev;
  assign cs_rise     = cs_sync & ~cs_prev;

  // Decoder and settings.
  dec_state_e dec_state;
  dec_state_e next_dec_state;
  logic [7:0] cmd;
  logic [7:0] next_cmd;
  logic [2:0] data_idx;
  logic [2:0] next_data_idx;
  logic [4:0] addr;
  logic [4:0] next_addr;
  logic       wr_lock;
  logic       next_wr_lock;
  logic [9:0] on_time;
  logic [9:0] next_on_time;
  logic [3:0] pair_code;
  logic [3:0] next_pair_code;
  op_mode_e   mode;
  op_mode_e   next_mode;
  cursor_s    cursor;
  cursor_s    next_cursor;
  logic       key_flag;
  logic       next_key_flag;
  logic       key_read_pend;
  logic       next_key_read_pend;
  logic       next_key_scan_stop;
  logic       do_write;
  logic       mem_we;
  logic [9:0] dim_raw;

  always_comb begin
    next_dec_state     = dec_state;
    next_cmd           = cmd;
    next_data_idx      = data_idx;
    next_addr          = addr;
    next_wr_lock       = wr_lock;
    next_on_time       = on_time;
    next_pair_code     = pair_code;
    next_mode          = mode;
    next_cursor        = cursor;
    next_key_read_pend = key_read_pend;
    next_key_scan_stop = 1'b0;
    do_write           = 1'b0;
    mem_we             = 1'b0;
    dim_raw            = {cmd[1:0], rx_data};
    if (byte_strobe) begin
      unique case (dec_state)
        ST_CMD: begin
          next_cmd       = rx_data;
          next_data_idx  = 3'h0;
          next_dec_state = ST_IGNORE;
          if (rx_data == CMD_NULL) begin
            next_dec_state = ST_IGNORE;
          end else begin
            case (rx_data[7:4])
              OP_ADDR, OP_CHAR, OP_DIM, OP_CURSOR: next_dec_state = ST_DATA;
              OP_DIGITS: next_pair_code = rx_data[3:0];
              OP_MODE: begin
                case (rx_data[2:0])
                  MODE_LAMP:   next_mode = OPM_LAMP;
                  MODE_LOWPWR: next_mode = OPM_LOWPWR;
                  MODE_BLANK:  next_mode = OPM_BLANK;
                  default:     next_mode = OPM_NORMAL;
                endcase
              end
              OP_KEYREAD: next_key_read_pend = 1'b1;
              default: next_dec_state = ST_IGNORE;
            endcase
          end
        end
        ST_DATA: begin
          next_data_idx = (data_idx == IDX_SAT) ? IDX_SAT : data_idx + 3'h1;
          unique case (cmd[7:4])
            OP_ADDR: begin
              if (data_idx == 3'h0) begin
                next_addr = rx_data[4:0];
              end else begin
                do_write = 1'b1;
              end
            end
            OP_CHAR: do_write = 1'b1;
            OP_DIM: begin
              if (data_idx == 3'h0) begin
                next_on_time = (dim_raw > DIM_MAX) ? DIM_MAX : dim_raw;
              end
            end
            OP_CURSOR: begin
              case (data_idx)
                CUR_L1_LO: next_cursor.line1_cursor_bits[7:0]  = rx_data;
                CUR_L1_HI: next_cursor.line1_cursor_bits[15:8] = rx_data;
                CUR_L2_LO: next_cursor.line2_cursor_bits[7:0]  = rx_data;
                CUR_L2_HI: next_cursor.line2_cursor_bits[15:8] = rx_data;
                default: ;
              endcase
            end
          endcase
        end
        ST_IGNORE: ;
      endcase
    end
    // The counter keeps moving past the last location, but writes stay
    // blocked so a long burst cannot overwrite the start of memory.
    if (do_write) begin
      mem_we    = !wr_lock;
      next_addr = addr + 5'h01;
      if (!wr_lock && (addr == ADDR_LAST)) begin
        next_wr_lock = 1'b1;
      end
    end
    // End of transfer: back to expecting a command byte.
    if (cs_rise) begin
      next_dec_state     = ST_CMD;
      next_wr_lock       = 1'b0;
      next_key_read_pend = 1'b0;
      next_key_scan_stop = key_read_pend;
    end
    // A new key event in the clearing cycle wins over the clear.
    next_key_flag = ((cs_rise && key_read_pend) ? 1'b0 : key_flag) | key_new_event;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dec_state     <= ST_CMD;
      cmd           <= 8'h00;
      data_idx      <= 3'h0;
      addr          <= ADDR_RESET;
      wr_lock       <= 1'b0;
      on_time       <= DIM_RESET;
      pair_code     <= PAIRS_RESET;
      mode          <= OPM_NORMAL;
      cursor        <= '0;
      key_flag      <= 1'b0;
      key_read_pend <= 1'b0;
      key_scan_stop <= 1'b0;
    end else begin
      dec_state     <= next_dec_state;
      cmd           <= next_cmd;
      data_idx      <= next_data_idx;
      addr          <= next_addr;
      wr_lock       <= next_wr_lock;
      on_time       <= next_on_time;
      pair_code     <= next_pair_code;
      mode          <= next_mode;
      cursor        <= next_cursor;
      key_flag      <= next_key_flag;
      key_read_pend <= next_key_read_pend;
      key_scan_stop <= next_key_scan_stop;
    end
  end

  // Outgoing frame, frozen while chip select is low so the link never sees
  // a byte change under it; the scan engine is asked to hold meanwhile.
  key_frame_s next_frame;

  always_comb begin
    next_frame = frame;
    if (cs_sync && cs_prev) begin
      next_frame.status = key_flag ? STAT_NEW : STAT_NONE;
      next_frame.rows   = key_state;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      frame <= {STAT_NONE, 30'h00000000};
    end else begin
      frame <= next_frame;
    end
  end

  // Display memory has no reset: its contents survive a device reset.
  logic [7:0] mem [MEM_DEPTH];
  logic [4:0] rd_loc;
  logic [4:0] pairs;

  always_ff @(posedge mclk) begin
    if (mem_we) begin
      mem[addr] <= rx_data;
    end
  end

  // Line 2 starts right after the last line-1 digit.
  always_comb begin
    pairs  = (pair_code == 4'h0) ? PAIRS_FULL : {1'b0, pair_code};
    rd_loc = disp_line ? pairs + {1'b0, disp_digit} : {1'b0, disp_digit};
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      disp_char     <= 8'h00;
      disp_digit_on <= 1'b0;
    end else begin
      disp_char     <= mem[rd_loc];
      disp_digit_on <= ({1'b0, disp_digit} < pairs);
    end
  end

  // Settings out; forcing leaves the memory untouched.
  assign seg_force_on     = (mode == OPM_LAMP);
  assign seg_force_off    = (mode == OPM_BLANK);
  assign low_power        = (mode == OPM_LOWPWR);
  assign dimming_on_time  = on_time;
  assign digit_pair_count = pairs;
  assign cursor_output    = ~cursor;
  assign key_change_irq_n = ~key_flag;
  assign key_scan_hold    = ~cs_sync;

endmodule

`default_nettype wire

/* verification/vfd_spi_command_decoder_assertions.sv */
// Concurrent checks on the ports of the serial command decoder.
// Assumes it is bound to the decoder top; all checks run on mclk.
`default_nettype none

module vfd_spi_command_decoder_assertions
  import vfd_cmd_pkg::*;
(
  input wire logic       mclk,              // Core clock.
  input wire logic       resetn,            // Reset, active low.
  input wire logic       spi_cs_n,          // Chip select.
  input wire logic       spi_miso_oe_n,     // Data out enable.
  input wire logic       key_new_event,     // New key data pulse.
  input wire logic       key_change_irq_n,  // Key interrupt.
  input wire logic       key_scan_stop,     // Stop scan pulse.
  input wire logic       key_scan_hold,     // Scan pause.
  input wire logic [3:0] disp_digit,        // Digit read address.
  input wire logic       disp_digit_on,     // Digit inside count.
  input wire logic       seg_force_on,      // Lamp test.
  input wire logic       seg_force_off,     // Blank.
  input wire logic       low_power,         // Low power.
  input wire logic [9:0] dimming_on_time,   // On-time.
  input wire logic [4:0] digit_pair_count   // Pairs shown.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // The chip select is asynchronous, so idle and busy need a few cycles to settle.
  sequence s_idle; spi_cs_n [*8]; endsequence
  sequence s_busy; !spi_cs_n [*4]; endsequence

  property p_oe_cs; spi_miso_oe_n == spi_cs_n; endproperty
  property p_dim_max; dimming_on_time <= DIM_MAX; endproperty
  property p_pairs; digit_pair_count inside {[5'h01:5'h10]}; endproperty
  property p_mode; $onehot0({seg_force_on, seg_force_off, low_power}); endproperty
  property p_stop_pulse; key_scan_stop |=> !key_scan_stop; endproperty
  property p_stop_clears;
    key_scan_stop && !key_new_event && !$past(key_new_event) |-> ##[0:1] key_change_irq_n;
  endproperty
  property p_clear_cause; $rose(key_change_irq_n) |-> key_scan_stop || $past(key_scan_stop); endproperty
  property p_event_sets; key_new_event |=> !key_change_irq_n; endproperty
  property p_hold; s_busy |-> key_scan_hold; endproperty
  property p_idle;
    s_idle |-> !key_scan_hold && $stable(dimming_on_time) && $stable(digit_pair_count);
  endproperty
  // The internal reset copy lags resetn by two cycles, hence the depth of three.
  property p_digit_on;
    $past(resetn, 3) |-> disp_digit_on == ({1'b0, $past(disp_digit)} < $past(digit_pair_count));
  endproperty

  a_oe_cs: assert property (p_oe_cs)
    else $error("data out enable differs from chip select");
  a_dim_max: assert property (p_dim_max)
    else $error("on-time above limit");
  a_pairs: assert property (p_pairs)
    else $error("pair count out of range");
  a_mode: assert property (p_mode)
    else $error("two modes at once");
  a_stop_pulse: assert property (p_stop_pulse)
    else $error("stop pulse too long");
  a_stop_clears: assert property (p_stop_clears)
    else $error("key interrupt kept after key read");
  a_clear_cause: assert property (p_clear_cause)
    else $error("key interrupt cleared without key read");
  a_event_sets: assert property (p_event_sets)
    else $error("new key data did not raise interrupt");
  a_hold: assert property (p_hold)
    else $error("scan not paused during transfer");
  a_idle: assert property (p_idle)
    else $error("settings moved while deselected");
  a_digit_on: assert property (p_digit_on)
    else $error("digit on flag wrong");
endmodule

`default_nettype wire

/* verification/spi_host_model.sv */
// Behavioural host acting as serial bus master, clock idle high.
// Assumes the bench loads tx and calls xfer; received bytes land in rx.
`default_nettype none

module spi_host_model (
  output var  logic sclk,  // Link clock, 160 ns period inside frames.
  output var  logic cs_n,  // Chip select.
  output var  logic mosi,  // Data to device.
  input  wire logic miso   // Data from device.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tx [0:7];
  logic [7:0] rx [0:7];

  // Chip select starts low for a moment, so its rise clears the link
  // counters even if the level at time zero goes unseen.
  initial begin
    sclk = 1'b1;
    cs_n = 1'b0;
    mosi = 1'b1;
    #1;
    cs_n = 1'b1;
  end

  // One framed transfer. The short wait moves chip select off the core clock
  // edge, and the odd lead time keeps every link edge off it as well.
  task automatic xfer(input int n);
    #1.5;
    cs_n = 1'b0;
    #100.3;
    for (int i = 0; i < n; i++) begin
      for (int b = 7; b >= 0; b--) begin
        sclk = 1'b0;
        mosi = tx[i][b];
        #80;
        sclk = 1'b1;
        rx[i][b] = miso;
        #80;
      end
    end
    cs_n = 1'b1;
    mosi = ~mosi;
    #400;
  endtask
endmodule

`default_nettype wire

/* verification/vfd_spi_command_decoder_tb.sv */
// Self-checking bench for the serial command decoder.
// Assumes the package, the host model and the checker are compiled first.
`default_nettype none

module vfd_spi_command_decoder_tb;
  import vfd_cmd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, resetn, sclk, cs_n, mosi, miso_o, oe_n, miso_w, miso_last;
  logic [29:0] key_state;
  logic key_new_event, irq_n, stop, hold, disp_line, force_on, force_off, lp, digit_on;
  logic [3:0] disp_digit;
  logic [7:0] disp_char;
  logic [9:0] on_time;
  logic [4:0] pairs;
  cursor_s cursor;
  int bad_count, checks_done, stop_cnt;

  vfd_spi_command_decoder dut_u (.mclk(mclk), .resetn(resetn), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_mosi(mosi), .spi_miso_o(miso_o), .spi_miso_oe_n(oe_n), .key_state(key_state),
    .key_new_event(key_new_event), .key_change_irq_n(irq_n), .key_scan_stop(stop),
    .key_scan_hold(hold), .disp_line(disp_line), .disp_digit(disp_digit), .disp_char(disp_char),
    .disp_digit_on(digit_on), .seg_force_on(force_on), .seg_force_off(force_off), .low_power(lp),
    .dimming_on_time(on_time), .digit_pair_count(pairs), .cursor_output(cursor));
  spi_host_model host_u (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_w));

  // A released data line has no pull, so it shows the inverse of its last level.
  always @(miso_o) if (!oe_n) miso_last = miso_o;
  assign miso_w = oe_n ? ~miso_last : miso_o;
  always #4 mclk = ~mclk;
  always @(posedge mclk) if (stop === 1'b1) stop_cnt++;

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmd(input int n, input logic [63:0] v);
    for (int i = 0; i < n; i++) host_u.tx[i] = v[8*(n-1-i) +: 8];
    host_u.xfer(n);
    repeat (2) @(posedge mclk);
  endtask

  task automatic mem(input logic ln, input logic [3:0] d, input logic [7:0] e);
    @(posedge mclk);
    disp_line <= ln;
    disp_digit <= d;
    repeat (2) @(posedge mclk);
    #1 check("disp_char", disp_char, e);
  endtask

  task automatic do_reset();
    resetn <= 1'b0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask

  task automatic t_write();
    cmd(4, 64'h85034142);
    mem(0, 4'h3, 8'h41);
    mem(0, 4'h4, 8'h42);
    cmd(2, 64'h9043);
    mem(0, 4'h5, 8'h43);
    cmd(3, 64'h800011);
    cmd(5, 64'h801EAABBCC);
    mem(1, 4'hE, 8'hAA);
    mem(1, 4'hF, 8'hBB);
    mem(0, 4'h0, 8'h11);
    cmd(2, 64'h90DD);
    mem(0, 4'h1, 8'hDD);
    $display("test write done");
  endtask

  task automatic t_dim();
    logic [15:0] c [5] = '{16'hA3FF, 16'hA234, 16'hA3D0, 16'hA3D1, 16'hA3CF};
    logic [9:0] e [5] = '{10'h3D0, 10'h234, 10'h3D0, 10'h3D0, 10'h3CF};
    for (int i = 0; i < 5; i++) begin
      cmd(2, {48'h0, c[i]});
      check("on_time", on_time, e[i]);
    end
    $display("test dim done");
  endtask

  task automatic t_digits();
    logic [7:0] c [4] = '{8'hB0, 8'hB1, 8'hBF, 8'hB4};
    logic [4:0] e [4] = '{5'h10, 5'h01, 5'h0F, 5'h04};
    for (int i = 0; i < 4; i++) begin
      cmd(1, {56'h0, c[i]});
      check("pairs", pairs, e[i]);
    end
    mem(1, 4'h1, 8'h43);
    check("digit_on", digit_on, 1'b1);
    mem(0, 4'h4, 8'h42);
    check("digit_on", digit_on, 1'b0);
    cmd(1, 64'hB0);
    $display("test digits done");
  endtask

  task automatic t_mode();
    for (int m = 0; m < 8; m++) begin
      cmd(1, 64'hC0 | m);
      check("modes", {force_on, force_off, lp}, {m == 1, m == 4, m == 2});
      mem(0, 4'h3, 8'h41);
    end
    cmd(1, 64'hC0);
    $display("test mode done");
  endtask

  task automatic t_cursor();
    cmd(5, 64'hD012345678);
    check("cursor", cursor, ~32'h78563412);
    $display("test cursor done");
  endtask

  task automatic t_keys();
    logic [5:0] row [5] = '{6'h15, 6'h2A, 6'h33, 6'h0C, 6'h3F};
    @(posedge mclk);
    key_state <= {row[4], row[3], row[2], row[1], row[0]};
    key_new_event <= 1'b1;
    @(posedge mclk);
    key_new_event <= 1'b0;
    repeat (4) @(posedge mclk);
    check("irq_n", irq_n, 1'b0);
    cmd(2, 64'hC000);
    check("status", {host_u.rx[0], host_u.rx[1]}, 16'h0000);
    cmd(7, 64'h00);
    for (int i = 1; i < 6; i++) check("row", host_u.rx[i][5:0], row[i-1]);
    check("wrap", {host_u.rx[0], host_u.rx[6]}, 16'h0000);
    check("null irq", {irq_n, stop_cnt[3:0]}, 5'h00);
    cmd(3, 64'hE0B5A3);
    check("key status", host_u.rx[0], 8'h00);
    check("row1", host_u.rx[1][5:0], row[0]);
    check("pairs", pairs, 5'h10);
    check("read irq", {irq_n, stop_cnt[3:0]}, 5'h11);
    cmd(2, 64'hC000);
    check("status", {host_u.rx[0], host_u.rx[1]}, 16'hFFFF);
    $display("test keys done");
  endtask

  task automatic t_unknown();
    cmd(2, 64'hF5A5);
    cmd(2, 64'h01B3);
    check("keep", {on_time, pairs, force_on, force_off, lp}, {10'h3CF, 5'h10, 3'h0});
    check("cursor", cursor, ~32'h78563412);
    $display("test unknown done");
  endtask

  task automatic t_reset();
    cmd(1, 64'hC1);
    cmd(1, 64'hB5);
    do_reset();
    check("reset", {on_time, pairs, force_on, irq_n}, {10'h0, 5'h10, 2'b01});
    cmd(2, 64'h9077);
    mem(0, 4'h0, 8'h77);
    mem(0, 4'h3, 8'h41);
    $display("test reset done");
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // The tests take a little over 100 us, so this limit leaves ample margin.
  initial begin
    #400us;
    bad_count++;
    complete_run();
  end

  initial begin
    {mclk, key_state, key_new_event, disp_line, disp_digit} = '0;
    // Reset starts high so that its assertion is a real falling edge for every process.
    resetn = 1'b1;
    do_reset();
    t_write();
    t_dim();
    t_digits();
    t_mode();
    t_cursor();
    t_keys();
    t_unknown();
    t_reset();
    complete_run();
  end
endmodule

bind vfd_spi_command_decoder vfd_spi_command_decoder_assertions chk_u (.mclk(mclk), .resetn(resetn),
  .spi_cs_n(spi_cs_n), .spi_miso_oe_n(spi_miso_oe_n), .key_new_event(key_new_event),
  .key_change_irq_n(key_change_irq_n), .key_scan_stop(key_scan_stop), .key_scan_hold(key_scan_hold),
  .disp_digit(disp_digit), .disp_digit_on(disp_digit_on), .seg_force_on(seg_force_on),
  .seg_force_off(seg_force_off), .low_power(low_power), .dimming_on_time(dimming_on_time),
  .digit_pair_count(digit_pair_count));

`default_nettype wire
